// *** osc_ctrl_pkg.sv ***
package osc_ctrl_pkg;

    // ------------------------------------------------------------------
    // register layout of the oscillator unit
    // ------------------------------------------------------------------
    localparam int                SOSC_EN_BIT      = 1;
    localparam int                REF_SEL_LSB      = 0;
    localparam int                REF_SEL_W        = 4;
    localparam int                REF_SWITCH_BIT   = 9;
    localparam int                REF_DIV_LSB      = 16;
    localparam int                REF_DIV_W        = 15;
    localparam int                REF_TRIM_LSB     = 23;
    localparam int                REF_TRIM_W       = 9;
    localparam int                PRIO_W           = 3;
    localparam int                SUBPRIO_W        = 2;
    localparam logic [2:0]        PRIO_NONE        = 3'h0;
    localparam int                NUM_SRC          = 16;

    // ------------------------------------------------------------------
    // port offsets of the controller (word addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0]        ADDR_OSC_CTRL    = 4'h0;
    localparam logic [3:0]        ADDR_REF_CTRL    = 4'h1;
    localparam logic [3:0]        ADDR_REF_TRIM    = 4'h2;
    localparam logic [3:0]        ADDR_LOCK        = 4'h3;
    localparam logic [3:0]        ADDR_IRQ_CFG     = 4'h4;
    localparam logic [3:0]        ADDR_STATUS      = 4'h5;
    localparam logic [3:0]        ADDR_POWER       = 4'h6;

    // lock field layout in the lock register: bit 0 = unlocked
    localparam logic [31:0]       RST_ZERO         = 32'h0000_0000;

    // sleep/idle/debug power state
    typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP, PWR_DEBUG}
        power_type;

endpackage

// *** osc_device_end.sv ***
`timescale 1ns/1ps
module osc_device_end (
    input  wire logic clk,
    input  wire logic resetn,
    osc_link_if.device link,
    output logic      soscEnable_ff,
    output logic      switchPending_ff
);
    import osc_ctrl_pkg::*;

    logic       failFlag_ff;
    logic       irqReq_ff;
    logic       soscRun_ff;
    logic       primaryRun_ff;
    logic       fastRcRun_ff;
    logic       lowPowerRcRun_ff;
    logic       startupDelay_ff;
    logic [3:0] refSel_ff;
    logic [14:0] refDiv_ff;
    logic [8:0] refTrim_ff;
    logic       wasSleep_ff;
    logic       soscWanted;
    logic       sleeping;
    power_type  mode;

    assign mode     = power_type'(link.powerMode);
    assign sleeping = (mode == PWR_SLEEP);

    // ------------------------------------------------------------------
    // secondary oscillator enable, written only through the shared lock
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            soscEnable_ff <= 1'b0;
        else if (link.unlocked)
            soscEnable_ff <= link.oscCtrl[SOSC_EN_BIT];
    end

    // enable holds it on; system clock use only while awake, sleep keep or a sleep user only in sleep
    always_comb
    begin
        soscWanted = soscEnable_ff || link.sysClkIsSosc;
        if (sleeping)
            soscWanted = soscEnable_ff || link.sleepKeep || link.sleepUser;
    end

    // ------------------------------------------------------------------
    // per-source run gates for sleep; idle and debug gate nothing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            soscRun_ff       <= 1'b0;
            primaryRun_ff    <= 1'b1;
            fastRcRun_ff     <= 1'b1;
            lowPowerRcRun_ff <= 1'b1;
        end
        else
        begin
            soscRun_ff       <= soscWanted;
            primaryRun_ff    <= !sleeping;
            fastRcRun_ff     <= !sleeping;
            lowPowerRcRun_ff <= !sleeping || link.wdtEnable;
        end
    end

    // start-up delay after sleep only; idle and debug never pay one
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wasSleep_ff     <= 1'b0;
            startupDelay_ff <= 1'b0;
        end
        else
        begin
            wasSleep_ff     <= sleeping;
            startupDelay_ff <= wasSleep_ff && !sleeping;
        end
    end

    // ------------------------------------------------------------------
    // reference clock: select live, divider/trim on switch request
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            refSel_ff        <= 4'h0;
            refDiv_ff        <= 15'h0000;
            refTrim_ff       <= 9'h000;
            switchPending_ff <= 1'b0;
        end
        else
        begin
            refSel_ff <= link.refCtrl[REF_SEL_LSB +: REF_SEL_W];
            switchPending_ff <= link.refCtrl[REF_SWITCH_BIT];
            // new values only take effect on the request edge
            if (link.refCtrl[REF_SWITCH_BIT] && !switchPending_ff)
            begin
                refDiv_ff  <= link.refCtrl[REF_DIV_LSB +: REF_DIV_W];
                refTrim_ff <= link.refTrim[REF_TRIM_LSB +: REF_TRIM_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // fail-safe event flag and interrupt request
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            failFlag_ff <= 1'b0;
        else if (link.primaryFail)                  // set wins
            failFlag_ff <= 1'b1;
        else if (link.flagClear)
            failFlag_ff <= 1'b0;
    end

    // priority zero blocks; subpriority ordering is the controller's
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irqReq_ff <= 1'b0;
        else
            irqReq_ff <= failFlag_ff && link.irqEnable
                         && (link.irqPrio != PRIO_NONE);
    end

    assign link.failFlag      = failFlag_ff;
    assign link.irqReq        = irqReq_ff;
    assign link.soscRun       = soscRun_ff;
    assign link.primaryRun    = primaryRun_ff;
    assign link.fastRcRun     = fastRcRun_ff;
    assign link.lowPowerRcRun = lowPowerRcRun_ff;
    assign link.startupDelay  = startupDelay_ff;
    assign link.refSel        = refSel_ff;
    assign link.refDiv        = refDiv_ff;
    assign link.refTrimVal    = refTrim_ff;

endmodule // osc_device_end

// *** osc_host_end.sv ***
`timescale 1ns/1ps
module osc_host_end (
    input  wire logic        clk,
    input  wire logic        resetn,
    osc_link_if.host         link,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic        sysClkIsSosc,
    input  wire logic        primaryFail,
    input  wire logic        sleepUser,
    output logic [31:0]      rdata_ff
);
    import osc_ctrl_pkg::*;

    logic [31:0] oscCtrl_ff;
    logic [31:0] refCtrl_ff;
    logic [31:0] refTrim_ff;
    logic        unlocked_ff;
    logic [2:0]  prio_ff;
    logic [1:0]  subPrio_ff;
    logic        irqEn_ff;
    logic        clear_ff;
    logic [1:0]  power_ff;
    logic        wdt_ff;
    logic        keep_ff;
    logic        fail1_ff;
    logic        fail2_ff;
    logic        failOld_ff;

    function automatic logic hit(input logic [3:0] a);
        hit = wr && (addr == a);
    endfunction

    // ------------------------------------------------------------------
    // register writes; lock opens with bit 0, gates only the oscillator control write
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oscCtrl_ff  <= RST_ZERO;
            refCtrl_ff  <= RST_ZERO;
            refTrim_ff  <= RST_ZERO;
            unlocked_ff <= 1'b0;
            prio_ff     <= 3'h0;
            subPrio_ff  <= 2'h0;
            irqEn_ff    <= 1'b0;
            power_ff    <= 2'h0;
            wdt_ff      <= 1'b0;
            keep_ff     <= 1'b0;
        end
        else
        begin
            if (hit(ADDR_LOCK))
                unlocked_ff <= wdata[0];
            if (hit(ADDR_OSC_CTRL) && unlocked_ff)
                oscCtrl_ff <= wdata;
            if (hit(ADDR_REF_CTRL))
                refCtrl_ff <= wdata;
            if (hit(ADDR_REF_TRIM))
                refTrim_ff <= wdata;
            if (hit(ADDR_IRQ_CFG))
            begin
                irqEn_ff   <= wdata[0];
                subPrio_ff <= wdata[2:1];
                prio_ff    <= wdata[5:3];
            end
            if (hit(ADDR_POWER))
            begin
                power_ff <= wdata[1:0];
                wdt_ff   <= wdata[2];
                keep_ff  <= wdata[3];
            end
        end
    end

    // status write with bit 0 set clears the event flag (one cycle)
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            clear_ff <= 1'b0;
        else
            clear_ff <= hit(ADDR_STATUS) && wdata[0];
    end

    // failure pin is asynchronous: two flops then edge detect
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fail1_ff   <= 1'b0;
            fail2_ff   <= 1'b0;
            failOld_ff <= 1'b0;
        end
        else
        begin
            fail1_ff   <= primaryFail;
            fail2_ff   <= fail1_ff;
            failOld_ff <= fail2_ff;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata_ff <= RST_ZERO;
        else if (rd)
            unique case (addr)
                ADDR_OSC_CTRL: rdata_ff <= oscCtrl_ff;
                ADDR_REF_CTRL: rdata_ff <= refCtrl_ff;
                ADDR_REF_TRIM: rdata_ff <= refTrim_ff;
                ADDR_LOCK:     rdata_ff <= {31'h0, unlocked_ff};
                ADDR_IRQ_CFG:  rdata_ff <= {26'h0, prio_ff, subPrio_ff,
                                            irqEn_ff};
                ADDR_STATUS:   rdata_ff <= {21'h0, link.refTrimVal[0],
                                            link.startupDelay,
                                            link.lowPowerRcRun,
                                            link.fastRcRun,
                                            link.primaryRun, link.soscRun,
                                            link.irqReq, 3'h0,
                                            link.failFlag};
                ADDR_POWER:    rdata_ff <= {28'h0, keep_ff, wdt_ff,
                                            power_ff};
                default:       rdata_ff <= RST_ZERO;
            endcase
        else
            rdata_ff <= RST_ZERO;
    end

    assign link.unlocked     = unlocked_ff;
    assign link.oscCtrl      = oscCtrl_ff;
    assign link.refCtrl      = refCtrl_ff;
    assign link.refTrim      = refTrim_ff;
    assign link.irqPrio      = prio_ff;
    assign link.irqSubPrio   = subPrio_ff;
    assign link.irqEnable    = irqEn_ff;
    assign link.flagClear    = clear_ff;
    assign link.powerMode    = power_ff;
    assign link.wdtEnable    = wdt_ff;
    assign link.sleepKeep    = keep_ff;
    assign link.sleepUser    = sleepUser;
    assign link.sysClkIsSosc = sysClkIsSosc;
    assign link.primaryFail  = fail2_ff && !failOld_ff;

endmodule // osc_host_end

// *** osc_link_asserts.sv ***
`timescale 1ns/1ps
module osc_link_asserts
    import osc_ctrl_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        unlocked,
    input wire logic [31:0] oscCtrl,
    input wire logic [31:0] refCtrl,
    input wire logic [31:0] refTrim,
    input wire logic [2:0]  irqPrio,
    input wire logic        irqEnable,
    input wire logic        flagClear,
    input wire logic [1:0]  powerMode,
    input wire logic        wdtEnable,
    input wire logic        sleepKeep,
    input wire logic        sleepUser,
    input wire logic        sysClkIsSosc,
    input wire logic        primaryFail,
    input wire logic        failFlag,
    input wire logic        irqReq,
    input wire logic        soscRun,
    input wire logic        primaryRun,
    input wire logic        fastRcRun,
    input wire logic        lowPowerRcRun,
    input wire logic        startupDelay,
    input wire logic [3:0]  refSel,
    input wire logic [14:0] refDiv,
    input wire logic [8:0]  refTrimVal
);
    // ------------------------------------------------------------------
    // link checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // three-cycle windows absorb the lag of up to two edges of the device end
    wire logic slp = powerMode == 2'(PWR_SLEEP);
    wire logic sEn = oscCtrl[SOSC_EN_BIT];
    wire logic irqOn = irqEnable && irqPrio != PRIO_NONE;

    a_lock_holds: assert property (
        !unlocked |=> $stable(oscCtrl)) else $error("write passed lock");
    a_enable_runs: assert property (
        sEn [*3] |-> soscRun) else $error("enabled osc stopped");
    a_idle_stops: assert property (
        (!sEn && !sysClkIsSosc && !sleepKeep && !sleepUser) [*3]
        |-> !soscRun) else $error("unused osc running");
    a_system_clock_select_keeps: assert property (
        (sysClkIsSosc && !slp) [*3] |-> soscRun)
        else $error("system clock osc stopped");
    a_sleep_gates: assert property (
        (slp && $stable(wdtEnable)) [*3] |-> !primaryRun && !fastRcRun
        && lowPowerRcRun == wdtEnable) else $error("sleep gating wrong");
    a_awake_runs: assert property (
        (!slp) [*3] |-> primaryRun && fastRcRun && lowPowerRcRun)
        else $error("source gated while awake");
    a_wake_delay: assert property (
        $fell(slp) |-> ##[1:3] startupDelay) else $error("no wake delay");
    a_delay_source: assert property (
        startupDelay |-> $past(slp) || $past(slp, 2) || $past(slp, 3))
        else $error("delay without sleep");
    a_fail_sets: assert property (
        primaryFail |=> failFlag) else $error("event flag not set");
    a_flag_sticky: assert property (
        failFlag && !flagClear |=> failFlag) else $error("flag self-cleared");
    a_irq_raise: assert property (
        failFlag && irqOn |=> irqReq) else $error("irq missing");
    a_irq_quiet: assert property (
        !(failFlag && irqOn) |=> !irqReq) else $error("irq spurious");
    a_ref_hold: assert property (
        !$rose(refCtrl[REF_SWITCH_BIT]) |=> $stable(refDiv)
        && $stable(refTrimVal)) else $error("divider moved unasked");
    a_ref_take: assert property (
        $rose(refCtrl[REF_SWITCH_BIT]) |=> refDiv == $past(refCtrl[30:16])
        && refTrimVal == $past(refTrim[31:23])) else $error("bad divider");
    a_sel_follows: assert property (
        1'h1 |=> refSel == $past(refCtrl[3:0])) else $error("bad select");

    c_fail: cover property ($rose(failFlag));
    c_wake: cover property (startupDelay);
    c_switch: cover property ($rose(refCtrl[REF_SWITCH_BIT]));
endmodule // osc_link_asserts

// *** osc_link_if.sv ***
`timescale 1ns/1ps
interface osc_link_if;
    logic        unlocked;      // shared system lock open
    logic [31:0] oscCtrl;       // oscillator control register image
    logic [31:0] refCtrl;       // reference clock control image
    logic [31:0] refTrim;       // reference clock trim image
    logic [2:0]  irqPrio;
    logic [1:0]  irqSubPrio;
    logic        irqEnable;
    logic        flagClear;     // one-cycle clear of event flag
    logic [1:0]  powerMode;     // power_type value
    logic        wdtEnable;
    logic        sleepKeep;
    logic        sleepUser;
    logic        sysClkIsSosc;
    logic        primaryFail;   // failure pulse from the monitor
    logic        failFlag;
    logic        irqReq;
    logic        soscRun;
    logic        primaryRun;
    logic        fastRcRun;
    logic        lowPowerRcRun;
    logic        startupDelay;
    logic [3:0]  refSel;
    logic [14:0] refDiv;
    logic [8:0]  refTrimVal;

    modport device (
        input  unlocked, oscCtrl, refCtrl, refTrim, irqPrio, irqSubPrio,
               irqEnable, flagClear, powerMode, wdtEnable, sleepKeep,
               sleepUser, sysClkIsSosc, primaryFail,
        output failFlag, irqReq, soscRun, primaryRun, fastRcRun,
               lowPowerRcRun, startupDelay, refSel, refDiv, refTrimVal
    );
    modport host (
        output unlocked, oscCtrl, refCtrl, refTrim, irqPrio, irqSubPrio,
               irqEnable, flagClear, powerMode, wdtEnable, sleepKeep,
               sleepUser, sysClkIsSosc, primaryFail,
        input  failFlag, irqReq, soscRun, primaryRun, fastRcRun,
               lowPowerRcRun, startupDelay, refSel, refDiv, refTrimVal
    );
endinterface // osc_link_if

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import osc_ctrl_pkg::*;
    logic        clk;
    logic        resetn;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        sysClkIsSosc;
    logic        primaryFail;
    logic        sleepUser;
    logic [31:0] rdata;
    logic        secondary_osc_enable;
    logic        switchPend;
    // crystal settling wait, scaled far down from the real milliseconds
    localparam int SETTLE = 16;
    int          miscompares;
    int          total_checks;
    int          cycles;
    int          wakes;
    localparam logic [31:0] M = 32'h0000_01F1;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;

    osc_link_if link ();
    osc_host_end osc_host_end_i (.clk(clk), .resetn(resetn), .link(link),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata),
        .sysClkIsSosc(sysClkIsSosc), .primaryFail(primaryFail),
        .sleepUser(sleepUser));
    osc_device_end osc_device_end_i (.clk(clk), .resetn(resetn),
        .link(link), .soscEnable_ff(secondary_osc_enable),
        .switchPending_ff(switchPend));
    osc_link_asserts osc_link_asserts_i (.clk(clk), .resetn(resetn),
        .unlocked(link.unlocked), .oscCtrl(link.oscCtrl),
        .refCtrl(link.refCtrl), .refTrim(link.refTrim),
        .irqPrio(link.irqPrio), .irqEnable(link.irqEnable),
        .flagClear(link.flagClear), .powerMode(link.powerMode),
        .wdtEnable(link.wdtEnable), .sleepKeep(link.sleepKeep),
        .sleepUser(link.sleepUser), .sysClkIsSosc(link.sysClkIsSosc),
        .primaryFail(link.primaryFail), .failFlag(link.failFlag),
        .irqReq(link.irqReq), .soscRun(link.soscRun),
        .primaryRun(link.primaryRun), .fastRcRun(link.fastRcRun),
        .lowPowerRcRun(link.lowPowerRcRun),
        .startupDelay(link.startupDelay), .refSel(link.refSel),
        .refDiv(link.refDiv), .refTrimVal(link.refTrimVal));

    // ------------------------------------------------------------------
    // clock, wake counter and hang guard
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // counts one-cycle start-up pulses seen on the link
    always @(posedge clk)
    begin
        wakes <= wakes + (link.startupDelay === 1'h1);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // waits after the strobe so the device end has caught up
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        check(rdata & m, e);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {resetn, addr, wdata, wr, rd} = '0;
        {sysClkIsSosc, primaryFail, sleepUser} = '0;
        {miscompares, total_checks, cycles, wakes} = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        rd_reg(ADDR_STATUS, M, 32'h0000_01C0);
        rd_reg(4'hF, ALL, 32'h0000_0000);
        $display("done: reset");
        wr_reg(ADDR_OSC_CTRL, 32'h0000_0002);
        rd_reg(ADDR_OSC_CTRL, ALL, 32'h0000_0000);
        check(32'(secondary_osc_enable), 32'h0000_0000);
        wr_reg(ADDR_LOCK, 32'h0000_0001);
        wr_reg(ADDR_OSC_CTRL, 32'h0000_0002);
        repeat (SETTLE) @(posedge clk);
        rd_reg(ADDR_STATUS, M, 32'h0000_01E0);
        wr_reg(ADDR_LOCK, 32'h0000_0000);
        wr_reg(ADDR_OSC_CTRL, 32'h0000_0000);
        rd_reg(ADDR_OSC_CTRL, ALL, 32'h0000_0002);
        $display("done: lock");
        wr_reg(ADDR_LOCK, 32'h0000_0001);
        sysClkIsSosc <= 1'h1;
        wr_reg(ADDR_OSC_CTRL, 32'h0000_0000);
        rd_reg(ADDR_STATUS, M, 32'h0000_01E0);
        sysClkIsSosc <= 1'h0;
        repeat (4) @(posedge clk);
        rd_reg(ADDR_STATUS, M, 32'h0000_01C0);
        $display("done: system clock");
        wr_reg(ADDR_OSC_CTRL, 32'h0000_0002);
        sysClkIsSosc <= 1'h1;
        repeat (4) @(posedge clk);
        sysClkIsSosc <= 1'h0;
        repeat (4) @(posedge clk);
        rd_reg(ADDR_STATUS, M, 32'h0000_01E0);
        wr_reg(ADDR_POWER, 32'h0000_0002);
        rd_reg(ADDR_STATUS, M, 32'h0000_0020);
        wr_reg(ADDR_OSC_CTRL, 32'h0000_0000);
        rd_reg(ADDR_STATUS, M, 32'h0000_0000);
        wr_reg(ADDR_POWER, 32'h0000_000E);
        rd_reg(ADDR_STATUS, M, 32'h0000_0120);
        wr_reg(ADDR_POWER, 32'h0000_0002);
        sleepUser <= 1'h1;
        repeat (4) @(posedge clk);
        rd_reg(ADDR_STATUS, M, 32'h0000_0020);
        sleepUser <= 1'h0;
        wr_reg(ADDR_POWER, 32'h0000_0000);
        rd_reg(ADDR_STATUS, M, 32'h0000_01C0);
        check(32'(wakes), 32'h0000_0001);
        wr_reg(ADDR_POWER, 32'h0000_0001);
        rd_reg(ADDR_STATUS, M, 32'h0000_01C0);
        wr_reg(ADDR_POWER, 32'h0000_0003);
        rd_reg(ADDR_STATUS, M, 32'h0000_01C0);
        wr_reg(ADDR_POWER, 32'h0000_0000);
        check(32'(wakes), 32'h0000_0001);
        $display("done: power modes");
        wr_reg(ADDR_IRQ_CFG, 32'h0000_003E);
        primaryFail <= 1'h1;
        repeat (6) @(posedge clk);
        primaryFail <= 1'h0;
        repeat (4) @(posedge clk);
        rd_reg(ADDR_STATUS, 32'h0000_0011, 32'h0000_0001);
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(ADDR_IRQ_CFG, 32'((i << 3) | ((i % 4) << 1) | 1));
            rd_reg(ADDR_STATUS, 32'h0000_0010,
                   (i != 0) ? 32'h0000_0010 : 32'h0000_0000);
            check(32'(link.irqSubPrio), 32'(i % 4));
        end
        rd_reg(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr_reg(ADDR_STATUS, 32'h0000_0001);
        rd_reg(ADDR_STATUS, 32'h0000_0011, 32'h0000_0000);
        $display("done: fail-safe");
        wr_reg(ADDR_REF_TRIM, 32'hFF80_0000);
        for (int i = 0; i < 16; i++)
        begin
            wr_reg(ADDR_REF_CTRL, 32'h7FFF_0000 | 32'(i));
            check(32'(link.refSel), 32'(i));
            check(32'(link.refDiv), 32'h0000_0000);
        end
        wr_reg(ADDR_REF_CTRL, 32'h7FFF_0205);
        check(32'(link.refDiv), 32'h0000_7FFF);
        check(32'(link.refTrimVal), 32'h0000_01FF);
        check(32'(switchPend), 32'h0000_0001);
        $display("done: reference clock");
        end_of_test();
    end
endmodule // tb
